//--- hdl/sicm_clk_if.sv
// Purpose: link between register logic and clock monitor
// Assumes: same clock on both sides
// Notes: ctrl drives enables, mon reports the source
`timescale 1ns/100ps
interface sicm_clk_if;
	import sicm_pkg::*;
	logic sup_en;
	logic halt;
	logic pll_en;
	logic on_safe;
	logic main_ok;
	sicm_src_e src;
	modport ctrl (output sup_en, output halt, output pll_en,
		input on_safe, input main_ok, input src);
	modport mon (input sup_en, input halt, input pll_en,
		output on_safe, output main_ok, output src);
endinterface

//--- hdl/sicm_clk_mon.sv
// Purpose: main oscillator monitor, spike filter and source switch
// Assumes: both oscillators well below half the block clock
// Notes: core clock is rebuilt from sampled oscillator levels
`timescale 1ns/100ps
`include "sicm_params.svh"
module sicm_clk_mon import sicm_pkg::*; #(
	parameter int FAIL_CYC = `SICM_FAIL_CYC,
	parameter int FILT_CYC = `SICM_FILT_CYC,
	parameter int RECOV_EDGES = `SICM_RECOV_EDGES
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Oscillator pins
	input wire logic main_osc_i,
	input wire logic safe_osc_i,
	// Control side
	sicm_clk_if.mon ctl,
	// Clock outputs
	output logic core_clk_o,
	output logic safe_osc_en_o
);
	if (FAIL_CYC < 2 || FAIL_CYC > 65535 || FILT_CYC < 1 ||
		FILT_CYC > 256 || RECOV_EDGES < 1 || RECOV_EDGES > 255) begin : g_chk
		$error("sicm_clk_mon: parameter out of range");
	end

	logic main_s1_r, main_s2_r, safe_s1_r, safe_s2_r;
	logic main_f_r, main_prev_r;
	logic [7:0] filt_r, edges_r;
	logic [15:0] idle_r;
	sicm_src_e src_r, src_nxt;
	logic main_edge, core_nxt;

	// Oscillators are foreign to the block clock
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_s1_r <= 1'b0;
			main_s2_r <= 1'b0;
			safe_s1_r <= 1'b0;
			safe_s2_r <= 1'b0;
		end else begin
			main_s1_r <= main_osc_i;
			main_s2_r <= main_s1_r;
			safe_s1_r <= safe_osc_i;
			safe_s2_r <= safe_s1_r;
		end
	end

	// A level must stand a few cycles before it is believed
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_f_r <= 1'b0;
			filt_r <= 8'h00;
		end else if (main_s2_r == main_f_r) begin
			filt_r <= 8'h00;
		end else if (!ctl.pll_en || filt_r == 8'(FILT_CYC - 1)) begin // RULE_06
			main_f_r <= main_s2_r;
			filt_r <= 8'h00;
		end else begin
			filt_r <= filt_r + 8'h01;
		end
	end

	assign main_edge = main_f_r ^ main_prev_r;

	// Loss is a long quiet spell; recovery needs a run of edges
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_prev_r <= 1'b0;
			idle_r <= 16'h0000;
			edges_r <= 8'h00;
			ctl.main_ok <= 1'b1;
		end else begin
			main_prev_r <= main_f_r;
			if (main_edge) begin
				idle_r <= 16'h0000;
			end else if (idle_r != 16'(FAIL_CYC)) begin
				idle_r <= idle_r + 16'h0001;
			end
			if (idle_r == 16'(FAIL_CYC)) begin // RULE_01
				ctl.main_ok <= 1'b0;
				edges_r <= 8'h00;
			end else if (!ctl.main_ok && main_edge) begin
				if (edges_r == 8'(RECOV_EDGES - 1)) begin // RULE_02
					ctl.main_ok <= 1'b1;
				end
				edges_r <= edges_r + 8'h01;
			end
		end
	end

	// Hand over only while both sides sit low, so no phase is cut; main to safe checks only the safe side
	always_comb begin
		src_nxt = src_r;
		unique case (src_r)
			sicm_src_off: begin
				if (!ctl.halt && !main_f_r) begin // RULE_10
					src_nxt = sicm_src_main;
				end
			end
			sicm_src_main: begin
				if (ctl.halt && !core_clk_o) begin
					src_nxt = sicm_src_off;
				end else if (ctl.sup_en && !ctl.main_ok && !safe_s2_r) begin
					src_nxt = sicm_src_safe; // RULE_01 RULE_21
				end
			end
			sicm_src_safe: begin
				if (ctl.halt && !core_clk_o) begin
					src_nxt = sicm_src_off;
				end else if ((ctl.main_ok || !ctl.sup_en) && !core_clk_o &&
					!main_f_r) begin
					src_nxt = sicm_src_main; // RULE_02 RULE_21
				end
			end
			default: src_nxt = sicm_src_off;
		endcase
		unique case (src_nxt)
			sicm_src_main: core_nxt = main_f_r;
			sicm_src_safe: core_nxt = safe_s2_r;
			default: core_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			src_r <= sicm_src_main;
			core_clk_o <= 1'b0;
			safe_osc_en_o <= 1'b0;
			ctl.on_safe <= 1'b0;
		end else begin
			src_r <= src_nxt;
			core_clk_o <= core_nxt;
			safe_osc_en_o <= ctl.sup_en && !ctl.halt; // RULE_09
			ctl.on_safe <= (src_nxt == sicm_src_safe);
		end
	end

	assign ctl.src = src_r;
endmodule

//--- hdl/sicm_params.svh
// Purpose: constants of the system integrity clock supervisor
// Assumes: one 100 MHz block clock, 8-bit control/status register
// Notes: offsets, bit positions, reset values and timing counts
// Notes on behaviour
// RULE_01 - Main clock lost: core runs from safe oscillator
// RULE_02 - Main clock back: return to it automatically
// RULE_03 - On safe oscillator: set clock fail flag bit 1
// RULE_04 - Fail flag cleared by read after recovery
// RULE_05 - Supervisor off: flag reads 0, enable ignored
// RULE_06 - Spike filter on main clock only with PLL
// RULE_07 - Interrupt needs enable bit and cleared mask
// RULE_08 - Interrupts wake from sleep, not deep stop
// RULE_09 - Deep stop freezes register, supervisor off
// RULE_10 - Interrupt wake resumes setup, reset restarts it
// RULE_11 - Bit 7 picks supply or sense pin
// RULE_12 - Bit 6 set: flag toggle requests interrupt
// RULE_13 - Bit 5 voltage low flag, hardware only
// RULE_14 - Bit 4 brownout reset flag, write zero clears
// RULE_15 - Software writes zero to reserved bit 3
// RULE_16 - Bit 2 enables clock fail interrupt
// RULE_17 - Register reads 000x 000x after reset
// RULE_18 - Bit 0 watchdog flag, cleared by brownout
// RULE_19 - Two flags encode the last reset cause
// RULE_20 - Brownout flag survives later external resets
// RULE_21 - Clock source switches are glitch free
`ifndef SICM_PARAMS_SVH
`define SICM_PARAMS_SVH
`define SICM_CSR_OFF 4'h0
`define SICM_CSR_RST 8'h00
`define SICM_B_VSEL 7
`define SICM_B_VIE 6
`define SICM_B_VLOW 5
`define SICM_B_BOR 4
`define SICM_B_RSVD 3
`define SICM_B_CIE 2
`define SICM_B_CFD 1
`define SICM_B_WDR 0
`define SICM_CLK_NS 10
`define SICM_FAIL_NS 2000
`define SICM_FAIL_CYC ((`SICM_FAIL_NS) / (`SICM_CLK_NS))
`define SICM_FILT_NS 20
`define SICM_FILT_CYC (((`SICM_FILT_NS) + (`SICM_CLK_NS) - 1) / (`SICM_CLK_NS))
`define SICM_RECOV_EDGES 8
`endif

//--- hdl/sicm_pkg.sv
// Purpose: types of the system integrity clock supervisor
// Assumes: nothing
// Notes: clock source states are one-hot
package sicm_pkg;
	typedef enum logic [2:0] {
		sicm_src_off = 3'b001,
		sicm_src_main = 3'b010,
		sicm_src_safe = 3'b100
	} sicm_src_e;
	typedef logic [7:0] sicm_byte_t;
endpackage

//--- hdl/sicm_top.sv
// Purpose: system integrity control/status register and supervisor
// Assumes: option, mode and reset-cause inputs are block-clock logic
// Notes: reset-cause flags live on the power-on reset only
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "sicm_params.svh"
module sicm_top import sicm_pkg::*; #(
	parameter int ADDR_W = 4,
	parameter int FAIL_CYC = `SICM_FAIL_CYC,
	parameter int FILT_CYC = `SICM_FILT_CYC,
	parameter int RECOV_EDGES = `SICM_RECOV_EDGES
) (
	// Clock and resets
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic por_nrst_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Options and modes
	input wire logic opt_clk_sup_en_i,
	input wire logic opt_brownout_en_i,
	input wire logic pll_en_i,
	input wire logic sleep_i,
	input wire logic deep_stop_i,
	// Reset cause from reset controller
	input wire logic bor_cause_i,
	input wire logic wdg_cause_i,
	// Voltage comparators
	input wire logic vdd_low_i,
	input wire logic sense_low_i,
	// CPU side
	input wire logic irq_mask_i,
	input wire logic vd_irq_ack_i,
	output logic irq_o,
	output logic wake_o,
	// Oscillators
	input wire logic main_osc_i,
	input wire logic safe_osc_i,
	output logic core_clk_o,
	output logic safe_osc_en_o
);
	if (ADDR_W < 4 || ADDR_W > 16) begin : g_chk
		$error("sicm_top: ADDR_W out of range");
	end

	sicm_clk_if cif ();

	logic vsel_r, vie_r, vlow_r, bor_r, cie_r, cfd_r, wdr_r;
	logic vd_pend_r, rst_done_r;
	logic vdd_s1_r, vdd_s2_r, sen_s1_r, sen_s2_r;
	logic hit, csr_wr, csr_rd, frz, vlow_in, vd_set, cfd_irq;
	sicm_byte_t csr_v;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == ADDR_W'(`SICM_CSR_OFF));
	endfunction

	assign hit = addr_hit(addr_i);
	assign frz = deep_stop_i;
	// Frozen register ignores software as well as hardware
	assign csr_wr = wr_i && hit && !frz; // RULE_09
	assign csr_rd = rd_i && hit && !frz;

	assign cif.sup_en = opt_clk_sup_en_i;
	assign cif.halt = deep_stop_i; // RULE_09
	assign cif.pll_en = pll_en_i;

	sicm_clk_mon #(
		.FAIL_CYC(FAIL_CYC),
		.FILT_CYC(FILT_CYC),
		.RECOV_EDGES(RECOV_EDGES)
	) u_mon (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.main_osc_i(main_osc_i),
		.safe_osc_i(safe_osc_i),
		.ctl(cif.mon),
		.core_clk_o(core_clk_o),
		.safe_osc_en_o(safe_osc_en_o)
	);

	// Comparator outputs are analog, hence two flops
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vdd_s1_r <= 1'b0;
			vdd_s2_r <= 1'b0;
			sen_s1_r <= 1'b0;
			sen_s2_r <= 1'b0;
		end else begin
			vdd_s1_r <= vdd_low_i;
			vdd_s2_r <= vdd_s1_r;
			sen_s1_r <= sense_low_i;
			sen_s2_r <= sen_s1_r;
		end
	end

	// Detector only works with the brownout option on
	assign vlow_in = opt_brownout_en_i && (vsel_r ? sen_s2_r : vdd_s2_r); // RULE_11
	assign vd_set = vie_r && !frz && (vlow_in != vlow_r); // RULE_12

	// Software settings; reset restarts them, wake by interrupt keeps them
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vsel_r <= 1'b0;
			vie_r <= 1'b0;
			cie_r <= 1'b0;
		end else if (csr_wr) begin // RULE_10
			vsel_r <= wdata_i[`SICM_B_VSEL]; // RULE_11
			vie_r <= wdata_i[`SICM_B_VIE]; // RULE_12
			cie_r <= wdata_i[`SICM_B_CIE]; // RULE_16
		end
	end

	// Voltage flag: no write path reaches it
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vlow_r <= 1'b0;
		end else if (!frz) begin
			vlow_r <= vlow_in; // RULE_13
		end
	end

	// Toggle request; a new toggle beats the service-entry clear
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vd_pend_r <= 1'b0;
		end else if (vd_set) begin
			vd_pend_r <= 1'b1; // RULE_12
		end else if (vd_irq_ack_i) begin
			vd_pend_r <= 1'b0; // RULE_12
		end
	end

	// Clock fail flag: held while on safe clock, read clears after
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfd_r <= 1'b0;
		end else if (!opt_clk_sup_en_i) begin
			cfd_r <= 1'b0; // RULE_05
		end else if (!frz) begin
			if (cif.on_safe) begin
				cfd_r <= 1'b1; // RULE_03
			end else if (csr_rd && cif.main_ok) begin
				cfd_r <= 1'b0; // RULE_04
			end
		end
	end

	// Marks the first cycle after release for cause capture
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_done_r <= 1'b0;
		end else begin
			rst_done_r <= 1'b1;
		end
	end

	// Cause flags ride on power-on reset so a later reset keeps them
	always_ff @(posedge clock_i or negedge por_nrst_i) begin
		if (!por_nrst_i) begin
			bor_r <= 1'b0;
			wdr_r <= 1'b0;
		end else begin
			if (csr_wr && !wdata_i[`SICM_B_BOR]) begin
				bor_r <= 1'b0; // RULE_14
			end
			if (csr_wr && !wdata_i[`SICM_B_WDR]) begin
				wdr_r <= 1'b0; // RULE_18
			end
			if (!rst_done_r && bor_cause_i) begin
				bor_r <= 1'b1; // RULE_14 RULE_19
				wdr_r <= 1'b0; // RULE_18
			end else if (!rst_done_r && wdg_cause_i) begin
				wdr_r <= 1'b1; // RULE_18 RULE_19 RULE_20
			end
		end
	end

	// Reserved bit always reads zero
	always_comb begin
		csr_v = `SICM_CSR_RST; // RULE_17
		csr_v[`SICM_B_VSEL] = vsel_r;
		csr_v[`SICM_B_VIE] = vie_r;
		csr_v[`SICM_B_VLOW] = vlow_r;
		csr_v[`SICM_B_BOR] = bor_r;
		csr_v[`SICM_B_CIE] = cie_r;
		csr_v[`SICM_B_CFD] = cfd_r && opt_clk_sup_en_i; // RULE_05
		csr_v[`SICM_B_WDR] = wdr_r;
	end

	// Read data stand one cycle only; other addresses read zero
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i && hit) begin
			rdata_o <= csr_v;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	assign cfd_irq = cfd_r && cie_r && opt_clk_sup_en_i; // RULE_05 RULE_16

	// Deep stop blocks both interrupt and wake
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			irq_o <= (cfd_irq || vd_pend_r) && !irq_mask_i && !frz; // RULE_07
			wake_o <= (cfd_irq || vd_pend_r) && !irq_mask_i && sleep_i &&
				!frz; // RULE_08
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i || !por_nrst_i);

	property p_cfd_set;
		cif.on_safe && opt_clk_sup_en_i && !frz |=> cfd_r;
	endproperty
	a_cfd_set: assert property (p_cfd_set) // RULE_03
		else $error("clock fail flag not set on safe clock");

	property p_cfd_clr;
		csr_rd && cif.main_ok && !cif.on_safe |=> !cfd_r;
	endproperty
	a_cfd_clr: assert property (p_cfd_clr) // RULE_04
		else $error("clock fail flag not cleared by read");

	property p_cfd_hold;
		cfd_r && !csr_rd && opt_clk_sup_en_i |=> cfd_r;
	endproperty
	a_cfd_hold: assert property (p_cfd_hold) // RULE_04
		else $error("clock fail flag lost without read");

	property p_cfd_off;
		rd_i && hit && !opt_clk_sup_en_i |=> !rdata_o[`SICM_B_CFD];
	endproperty
	a_cfd_off: assert property (p_cfd_off) // RULE_05
		else $error("clock fail flag read one with supervisor off");

	property p_mask;
		irq_mask_i |=> !irq_o;
	endproperty
	a_mask: assert property (p_mask) // RULE_07
		else $error("interrupt raised while masked");

	property p_deep_nowake;
		deep_stop_i |=> !wake_o && !irq_o;
	endproperty
	a_deep_nowake: assert property (p_deep_nowake) // RULE_08
		else $error("wake out of deep stop by interrupt");

	property p_freeze;
		deep_stop_i && $past(deep_stop_i) && opt_clk_sup_en_i &&
			$stable(opt_clk_sup_en_i) |-> $stable(csr_v);
	endproperty
	a_freeze: assert property (p_freeze) // RULE_09
		else $error("register changed in deep stop");

	property p_safe_off;
		deep_stop_i |=> !safe_osc_en_o;
	endproperty
	a_safe_off: assert property (p_safe_off) // RULE_09
		else $error("safe oscillator enabled in deep stop");

	property p_vd_toggle;
		vd_set |=> vd_pend_r ##1 (vd_pend_r || $past(vd_irq_ack_i));
	endproperty
	a_vd_toggle: assert property (p_vd_toggle) // RULE_12
		else $error("voltage toggle request lost");

	property p_vd_ack;
		vd_irq_ack_i && !vd_set |=> !vd_pend_r;
	endproperty
	a_vd_ack: assert property (p_vd_ack) // RULE_12
		else $error("voltage request not cleared on service");

	property p_rst_val;
		!rst_done_r |-> csr_v[7:5] == 3'h0 && csr_v[3:1] == 3'h0;
	endproperty
	a_rst_val: assert property (p_rst_val) // RULE_17
		else $error("register reset value wrong");

	property p_rsvd;
		rd_i |=> !rdata_o[`SICM_B_RSVD];
	endproperty
	a_rsvd: assert property (p_rsvd) // RULE_15
		else $error("reserved bit read as one");

	property p_stop_off;
		deep_stop_i && !core_clk_o |=> cif.src == sicm_src_off;
	endproperty
	a_stop_off: assert property (p_stop_off) // RULE_09
		else $error("core clock source kept in deep stop");

	// A source change while the core clock is high would cut its phase
	property p_switch_low;
		$changed(cif.src) |-> !core_clk_o;
	endproperty
	a_switch_low: assert property (p_switch_low) // RULE_21
		else $error("clock source changed with core clock high");

	c_safe: cover property (!cif.on_safe ##1 cif.on_safe);
	c_back: cover property (cif.on_safe ##1 !cif.on_safe);
	c_vd_irq: cover property (vd_set ##[1:20] irq_o);
	c_wake: cover property (sleep_i ##1 wake_o);
endmodule

//--- tb/sicm_osc_model.sv
// Purpose: main and safe oscillator model for the supervisor bench
// Assumes: main half period well above the spike filter length
// Notes: a stopped main clock rests low; spikes only while stopped
`timescale 1ns/100ps
module sicm_osc_model #(
	parameter int MAIN_HALF_NS = 50,
	parameter int SAFE_HALF_NS = 200
) (
	// Controls from the bench
	input wire logic run_i,
	input wire logic spike_i,
	input wire logic safe_en_i,
	// Oscillator outputs
	output logic main_osc_o,
	output logic safe_osc_o
);
	// Short spikes prove the filter, they must not look like a clock
	initial begin
		main_osc_o = 1'b0;
		forever begin
			if (run_i) begin
				#(MAIN_HALF_NS) main_osc_o = ~main_osc_o;
			end else begin
				main_osc_o = 1'b0;
				#45;
				if (spike_i) begin
					main_osc_o = 1'b1;
				end
				#5 main_osc_o = 1'b0;
			end
		end
	end
	// Safe oscillator stands low while not enabled
	initial begin
		safe_osc_o = 1'b0;
		forever begin
			#(SAFE_HALF_NS);
			safe_osc_o = safe_en_i ? ~safe_osc_o : 1'b0;
		end
	end
endmodule

//--- tb/sicm_top_tb.sv
// Purpose: self-checking bench of the system integrity supervisor
// Assumes: short failure and recovery counts set at the instance
// Notes: expectations come from bench constants, tables and exp_rw, not from the design
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
	check_count++; \
	if ((got) !== (ex)) begin \
		errors++; \
		$display("wrong value %s expected %h seen %h", nm, ex, got); \
	end \
end
module sicm_top_tb;
	import sicm_pkg::*;
	logic clock_i;
	logic nrst = 1'b0, por_nrst = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	sicm_byte_t wdata = 8'h00;
	logic opt_sup = 1'b1, opt_bo = 1'b1, pll = 1'b0, sleep = 1'b0;
	logic dstop = 1'b0, borc = 1'b0, wdgc = 1'b0, vdd_low = 1'b0;
	logic sense_low = 1'b0, mask = 1'b0, ack = 1'b0;
	logic run = 1'b1, spike = 1'b0;
	wire logic main_osc, safe_osc, core_clk, safe_en, irq, wake;
	wire sicm_byte_t rdata;
	int errors = 0, check_count = 0, cyc = 0, i;
	int core_edges = 0, n0;
	sicm_byte_t v, w;
	logic bs[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic ws[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	sicm_byte_t es[4] = '{8'h01, 8'h10, 8'h10, 8'h11};

	sicm_top #(.FAIL_CYC(20), .FILT_CYC(2), .RECOV_EDGES(2)) dut (
		.clock_i(clock_i), .nrst_i(nrst), .por_nrst_i(por_nrst),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .opt_clk_sup_en_i(opt_sup),
		.opt_brownout_en_i(opt_bo), .pll_en_i(pll), .sleep_i(sleep),
		.deep_stop_i(dstop), .bor_cause_i(borc), .wdg_cause_i(wdgc),
		.vdd_low_i(vdd_low), .sense_low_i(sense_low),
		.irq_mask_i(mask), .vd_irq_ack_i(ack), .irq_o(irq),
		.wake_o(wake), .main_osc_i(main_osc), .safe_osc_i(safe_osc),
		.core_clk_o(core_clk), .safe_osc_en_o(safe_en));
	sicm_osc_model osc (.run_i(run), .spike_i(spike),
		.safe_en_i(safe_en), .main_osc_o(main_osc),
		.safe_osc_o(safe_osc));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge core_clk) core_edges++;
	// Readable bits after a write; bit 3 and flag bits 4, 1, 0 read back 0, bit 5 reads vl
	function automatic sicm_byte_t exp_rw(sicm_byte_t d, logic vl);
		return (d & 8'hc4) | {2'b00, vl, 5'b00000};
	endfunction
	task automatic cw(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic reg_wr(input logic [3:0] a, input sicm_byte_t d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output sicm_byte_t d);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse_ack();
		@(posedge clock_i);
		ack <= 1'b1;
		@(posedge clock_i);
		ack <= 1'b0;
	endtask
	// Bounded wait for the interrupt line to reach a level
	task automatic wait_irq(input logic lvl, input int lim);
		for (int k = 0; k < lim && irq !== lvl; k++) begin
			cw(1);
		end
	endtask
	task automatic do_rst(input logic b, input logic c);
		@(posedge clock_i);
		borc <= b;
		wdgc <= c;
		nrst <= 1'b0;
		cw(2);
		nrst <= 1'b1;
		cw(2);
	endtask
	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(32'h716fc1eb));
		cw(12);
		nrst <= 1'b1;
		por_nrst <= 1'b1;
		cw(2);
		reg_rd(4'h0, v);
		`CHK("csr after reset", 8'h00, v)
		end_test("reset");
		for (i = 0; i < 4; i++) begin
			w = sicm_byte_t'($urandom);
			w[3] = 1'b0;
			reg_wr(4'h0, w);
			reg_rd(4'h0, v);
			`CHK("csr readback", exp_rw(w, 1'b0), v)
		end
		reg_wr(4'h5, 8'hff);
		reg_rd(4'h5, v);
		`CHK("unmapped read", 8'h00, v)
		reg_rd(4'h0, v);
		`CHK("csr kept", exp_rw(w, 1'b0), v)
		end_test("access");
		reg_wr(4'h0, 8'h40);
		vdd_low <= 1'b1;
		wait_irq(1'b1, 12);
		`CHK("vd irq on fall", 1'b1, irq)
		reg_rd(4'h0, v);
		`CHK("vlow set", exp_rw(8'h40, 1'b1), v)
		pulse_ack();
		cw(2);
		`CHK("vd irq acked", 1'b0, irq)
		vdd_low <= 1'b0;
		wait_irq(1'b1, 12);
		`CHK("vd irq on rise", 1'b1, irq)
		pulse_ack();
		mask <= 1'b1;
		vdd_low <= 1'b1;
		cw(8);
		`CHK("masked irq", 1'b0, irq)
		mask <= 1'b0;
		wait_irq(1'b1, 4);
		`CHK("unmasked irq", 1'b1, irq)
		reg_wr(4'h0, 8'hc0);
		sense_low <= 1'b1;
		cw(8);
		vdd_low <= 1'b0;
		cw(8);
		reg_rd(4'h0, v);
		`CHK("vlow from sense pin", exp_rw(8'hc0, 1'b1), v)
		// Clear the old request first, so only the new toggle could raise it
		reg_wr(4'h0, 8'h80);
		pulse_ack();
		sense_low <= 1'b0;
		cw(10);
		`CHK("no irq with vie off", 1'b0, irq)
		end_test("voltage");
		reg_wr(4'h0, 8'h04);
		pll <= 1'b1;
		spike <= 1'b1;
		run <= 1'b0;
		wait_irq(1'b1, 400);
		`CHK("clock fail irq", 1'b1, irq)
		`CHK("safe osc on", 1'b1, safe_en)
		reg_rd(4'h0, v);
		`CHK("cfd set", 8'h06, v)
		reg_rd(4'h0, v);
		`CHK("cfd kept", 8'h06, v)
		n0 = core_edges;
		cw(100);
		`CHK("core rate on safe", 1'b1, (core_edges - n0) inside {[2:3]})
		sleep <= 1'b1;
		cw(3);
		`CHK("wake from sleep", 1'b1, wake)
		dstop <= 1'b1;
		cw(3);
		`CHK("no wake in stop", 1'b0, wake)
		`CHK("safe osc off in stop", 1'b0, safe_en)
		n0 = core_edges;
		cw(50);
		`CHK("core stopped in stop", 1'b1, core_edges == n0)
		reg_wr(4'h0, 8'h00);
		dstop <= 1'b0;
		sleep <= 1'b0;
		reg_rd(4'h0, v);
		`CHK("csr frozen", 8'h06, v)
		spike <= 1'b0;
		run <= 1'b1;
		for (i = 0; i < 60; i++) begin
			reg_rd(4'h0, v);
			if (v[1] === 1'b0) break;
			cw(5);
		end
		`CHK("cfd cleared", 8'h04, v)
		cw(2);
		`CHK("clock irq gone", 1'b0, irq)
		n0 = core_edges;
		cw(100);
		`CHK("core rate on main", 1'b1, (core_edges - n0) inside {[9:11]})
		end_test("clock fail");
		opt_sup <= 1'b0;
		run <= 1'b0;
		cw(300);
		reg_rd(4'h0, v);
		`CHK("cfd with option off", 8'h04, v)
		`CHK("irq with option off", 1'b0, irq)
		run <= 1'b1;
		opt_sup <= 1'b1;
		pll <= 1'b0;
		cw(20);
		end_test("option off");
		reg_wr(4'h0, 8'hc4);
		for (i = 0; i < 4; i++) begin
			do_rst(bs[i], ws[i]);
			reg_rd(4'h0, v);
			`CHK("reset cause", es[i], v)
		end
		reg_wr(4'h0, 8'h00);
		reg_rd(4'h0, v);
		`CHK("flags cleared", 8'h00, v)
		end_test("reset cause");
		print_verdict();
	end
endmodule
